// [src/half_rate_divider.sv]
`timescale 1ns/10ps
// Re-times the main oscillator and derives its half-rate output
module half_rate_divider (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic osc_full,
	output logic      full_q,
	output logic      half_q
);
	logic full_d;
	logic half_d;

	assign full_d = osc_full;
	assign half_d = (osc_full & ~full_q) ? ~half_q : half_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			full_q <= 1'b0;
			half_q <= 1'b0;
		end else if (ce) begin
			full_q <= full_d;
			half_q <= half_d;
		end
	end
endmodule

// [src/osc_ctrl_pkg.sv]
package osc_ctrl_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CTRL0      = 8'hE0;
	localparam logic [7:0] IDX_MAIN_TRIM  = 8'hE8;
	localparam logic [7:0] IDX_LOW_TRIM   = 8'hE9;
	localparam logic [7:0] IDX_XTAL_TRIM  = 8'hEB;
	localparam logic [7:0] IDX_TRIM_3V3   = 8'hF0;
	localparam logic [7:0] IDX_STATUS     = 8'hF1;

	// oscillator_control_0 fields
	localparam int CR0_SLOW_SEL_BIT = 7;
	localparam int CR0_PLL_BIT      = 6;
	localparam int CR0_SLEEP_LSB    = 3;
	localparam int CR0_CPU_LSB      = 0;
	localparam logic [7:0] CR0_RESET     = 8'h00;
	localparam logic [1:0] SLEEP_ONE_SEC = 2'h3;

	// low_speed_osc_trim fields
	localparam int LOW_DISABLE_BIT = 6;
	localparam logic [7:0] LOW_TRIM_WMASK = 8'h7F;

	// crystal_osc_trim fields; bits 5:4 reserved, held at zero
	localparam int XTAL_DUTY_LSB = 6;
	localparam logic [7:0] XTAL_TRIM_WMASK = 8'hCF;

	// status fields
	localparam int ST_ACTIVE_XTAL = 0;
	localparam int ST_PENDING     = 1;
	localparam int ST_PLL_SETTLED = 2;
	localparam int ST_LOW_ON      = 3;

	// Oscillator figures
	localparam int MAIN_OSC_MHZ  = 48;
	localparam int HALF_OSC_MHZ  = MAIN_OSC_MHZ / 2;
	localparam int XTAL_HZ       = 32768;
	localparam int PLL_OUT_HZ    = 23986000;
	localparam logic [9:0] PLL_MULT =
		10'((PLL_OUT_HZ + XTAL_HZ / 2) / XTAL_HZ);

	// Lock wait
	localparam int CLK_MHZ         = 200;
	localparam int PLL_SETTLE_MS   = 10;
	localparam int PLL_SETTLE_CYC  = PLL_SETTLE_MS * 1000 * CLK_MHZ;

	typedef struct packed {
		logic [7:0] main_trim;
		logic [5:0] low_trim;
		logic       low_osc_on;
		logic       xtal_enable;
		logic       slow_src_xtal;
		logic       pll_enable;
		logic [9:0] pll_mult;
		logic [2:0] cpu_sel;
		logic [1:0] sleep_sel;
		logic [9:0] sleep_hz;
		logic [9:0] duty_div;
		logic [1:0] xtal_amp;
		logic [1:0] xtal_bias;
	} osc_ctrl_s;

	function automatic logic [9:0] duty_divisor(input logic [1:0] code);
		case (code)
			2'h0:    duty_divisor = 10'h080;
			2'h1:    duty_divisor = 10'h200;
			2'h2:    duty_divisor = 10'h020;
			default: duty_divisor = 10'h008;
		endcase
	endfunction

	function automatic logic [9:0] sleep_rate_hz(input logic [1:0] code);
		case (code)
			2'h0:    sleep_rate_hz = 10'h200;
			2'h1:    sleep_rate_hz = 10'h040;
			2'h2:    sleep_rate_hz = 10'h008;
			default: sleep_rate_hz = 10'h001;
		endcase
	endfunction

endpackage

// [src/oscillator_source_control.sv]
`timescale 1ns/10ps
// How it works
// - Main oscillator gives 48 and 24 MHz
// - Reset loads 5V trim; 3.3V readable
// - Main trim write-only; larger means faster
// - Reset loads factory six-bit low trim
// - Disable bit 6 stops low oscillator
// - Low oscillator usable as slow time base
// - After reset slow clock uses low oscillator
// - Crystal enabled only by select bit 7
// - Low oscillator drives until terminal count
// - Switchover independent of sleep interrupt enable
// - Duty field decodes 128, 512, 32, 8
// - Crystal amp, bias factory; bits 5:4 zero
// - Locked oscillator runs at 23.986 MHz
// - Processor select write takes effect immediately
// - Control bit 7 selects slow source
// - Control bit 6 enables phase lock
// - Sleep code 11 selects one-second period
module oscillator_source_control #(
	parameter int         ADDR_W          = 10,
	parameter int         SETTLE_CYCLES   = osc_ctrl_pkg::PLL_SETTLE_CYC,
	parameter logic [7:0] MAIN_TRIM_5V    = 8'h80,
	parameter logic [7:0] MAIN_TRIM_3V3   = 8'h70,
	parameter logic [5:0] LOW_TRIM_INIT   = 6'h20,
	parameter logic [1:0] XTAL_DUTY_INIT  = 2'h0,
	parameter logic [1:0] XTAL_AMP_INIT   = 2'h1,
	parameter logic [1:0] XTAL_BIAS_INIT  = 2'h1
) (
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              ce,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic      [31:0]       wb_dat_o,
	output logic                   wb_ack_o,
	input  wire logic              main_osc_48,
	input  wire logic              lowspeed_osc_in,
	input  wire logic              crystal_osc_in,
	input  wire logic              sleep_terminal_count,
	output osc_ctrl_pkg::osc_ctrl_s osc_ctrl_o,
	output logic                   slow_clk_o,
	output logic                   clk48_o,
	output logic                   clk24_o
);
	generate
		if (ADDR_W < 10) begin : g_bad_addr
			$error("ADDR_W must be at least 10");
		end
		if (SETTLE_CYCLES < 1) begin : g_bad_settle
			$error("SETTLE_CYCLES must be at least 1");
		end
	endgenerate

	// Reset release through two flops
	logic rst_meta_q;
	logic rst_n;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// Register index compare shared by every decode
	function automatic logic index_hit(input logic [7:0] a,
		input logic [7:0] target);
		index_hit = (a == target);
	endfunction

	// Bus decode
	logic [7:0] idx;
	logic       req;
	logic       wr_go;
	logic       hit_ctrl0;
	logic       hit_main;
	logic       hit_low;
	logic       hit_xtal;
	logic       hit_3v3;
	logic       hit_status;
	logic       ack_d;

	assign idx        = wb_adr_i[9:2];
	assign req        = wb_cyc_i & wb_stb_i;
	assign ack_d      = req & ~wb_ack_o;
	// Write lands on the edge where the master samples ack
	assign wr_go      = req & wb_we_i & wb_ack_o & wb_sel_i[0];
	assign hit_ctrl0  = index_hit(idx, osc_ctrl_pkg::IDX_CTRL0);
	assign hit_main   = index_hit(idx, osc_ctrl_pkg::IDX_MAIN_TRIM);
	assign hit_low    = index_hit(idx, osc_ctrl_pkg::IDX_LOW_TRIM);
	assign hit_xtal   = index_hit(idx, osc_ctrl_pkg::IDX_XTAL_TRIM);
	assign hit_3v3    = index_hit(idx, osc_ctrl_pkg::IDX_TRIM_3V3);
	assign hit_status = index_hit(idx, osc_ctrl_pkg::IDX_STATUS);

	// Register state
	logic [7:0] ctrl0_q;
	logic [7:0] ctrl0_d;
	logic [7:0] main_trim_q;
	logic [7:0] main_trim_d;
	logic [7:0] low_trim_q;
	logic [7:0] low_trim_d;
	logic [7:0] xtal_trim_q;
	logic [7:0] xtal_trim_d;
	logic       active_xtal_q;
	logic       active_xtal_d;
	logic       pll_settled;

	// One write strobe per writable register
	logic wr_ctrl0;
	logic wr_main;
	logic wr_low;
	logic wr_xtal;

	assign wr_ctrl0    = wr_go & hit_ctrl0;
	assign wr_main     = wr_go & hit_main;
	assign wr_low      = wr_go & hit_low;
	assign wr_xtal     = wr_go & hit_xtal;

	assign ctrl0_d     = wr_ctrl0 ? wb_dat_i[7:0] : ctrl0_q;
	assign main_trim_d = wr_main ? wb_dat_i[7:0]
		: main_trim_q;
	assign low_trim_d  = wr_low
		? (wb_dat_i[7:0] & osc_ctrl_pkg::LOW_TRIM_WMASK) : low_trim_q;
	assign xtal_trim_d = wr_xtal
		? (wb_dat_i[7:0] & osc_ctrl_pkg::XTAL_TRIM_WMASK)
		: xtal_trim_q;

	// Pending selection follows bit 7; active moves only on terminal count
	logic sel_xtal;
	assign sel_xtal      = ctrl0_q[osc_ctrl_pkg::CR0_SLOW_SEL_BIT];
	assign active_xtal_d = sleep_terminal_count ? sel_xtal
		: active_xtal_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl0_q <= osc_ctrl_pkg::CR0_RESET;
		end else if (ce) begin
			ctrl0_q <= ctrl0_d;
		end
	end

	// Factory value for the higher supply comes out of reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			main_trim_q <= MAIN_TRIM_5V;
		end else if (ce) begin
			main_trim_q <= main_trim_d;
		end
	end

	// Disable bit clears at reset, so the low oscillator starts running
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_trim_q <= {2'h0, LOW_TRIM_INIT};
		end else if (ce) begin
			low_trim_q <= low_trim_d;
		end
	end

	// Reserved bits 5:4 leave reset as zero and cannot be written
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xtal_trim_q <= {XTAL_DUTY_INIT, 2'h0, XTAL_AMP_INIT,
				XTAL_BIAS_INIT};
		end else if (ce) begin
			xtal_trim_q <= xtal_trim_d;
		end
	end

	// Crystal is never the active source straight after reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			active_xtal_q <= 1'b0;
		end else if (ce) begin
			active_xtal_q <= active_xtal_d;
		end
	end

	// Lock wait indication for firmware
	settle_timer #(
		.COUNT (SETTLE_CYCLES)
	) u_settle (
		.clk    (clk),
		.rst_n  (rst_n),
		.ce     (ce),
		.run    (ctrl0_q[osc_ctrl_pkg::CR0_PLL_BIT]),
		.done_q (pll_settled)
	);

	// Read data
	logic [7:0] status;
	logic [7:0] rdata;

	logic       switch_pending;
	logic       low_running;
	logic [7:0] rd_ctrl0;
	logic [7:0] rd_3v3;
	logic [7:0] rd_status;

	assign switch_pending = sel_xtal ^ active_xtal_q;
	assign low_running    = ~low_trim_q[osc_ctrl_pkg::LOW_DISABLE_BIT];
	assign status = {4'h0, low_running, pll_settled, switch_pending,
		active_xtal_q};
	// Writable trim registers are write-only and read back as zero; the 3.3V trim reads back
	assign rd_ctrl0  = hit_ctrl0 ? ctrl0_q : 8'h00;
	assign rd_3v3    = hit_3v3 ? MAIN_TRIM_3V3 : 8'h00;
	assign rd_status = hit_status ? status : 8'h00;
	assign rdata     = rd_ctrl0 | rd_3v3 | rd_status;

	// Ack is a one-cycle pulse; a held request is answered again every second cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
		end else if (ce) begin
			wb_ack_o <= ack_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (ce && ack_d) begin
			wb_dat_o <= {24'h00_0000, rdata};
		end
	end

	// Control outputs toward the analog cells
	osc_ctrl_pkg::osc_ctrl_s ctrl_d;
	logic [1:0]              sleep_code;
	logic [1:0]              duty_code;
	logic [2:0]              cpu_code;
	logic                    lock_on;
	logic [5:0]              low_code;
	logic [1:0]              amp_code;
	logic [1:0]              bias_code;

	// Field views of the register bits
	assign sleep_code = ctrl0_q[osc_ctrl_pkg::CR0_SLEEP_LSB +: 2];
	assign duty_code  = xtal_trim_q[osc_ctrl_pkg::XTAL_DUTY_LSB +: 2];
	assign cpu_code   = ctrl0_q[osc_ctrl_pkg::CR0_CPU_LSB +: 3];
	assign lock_on    = ctrl0_q[osc_ctrl_pkg::CR0_PLL_BIT];
	assign low_code   = low_trim_q[5:0];
	assign amp_code   = xtal_trim_q[3:2];
	assign bias_code  = xtal_trim_q[1:0];

	always_comb begin
		ctrl_d               = '0;
		ctrl_d.main_trim     = main_trim_q;
		ctrl_d.low_trim      = low_code;
		ctrl_d.low_osc_on    = low_running;
		ctrl_d.xtal_enable   = sel_xtal;
		ctrl_d.slow_src_xtal = active_xtal_q;
		ctrl_d.pll_enable    = lock_on;
		ctrl_d.pll_mult      = osc_ctrl_pkg::PLL_MULT;
		ctrl_d.cpu_sel       = cpu_code;
		ctrl_d.sleep_sel     = sleep_code;
		ctrl_d.sleep_hz      = osc_ctrl_pkg::sleep_rate_hz(sleep_code);
		ctrl_d.duty_div      = osc_ctrl_pkg::duty_divisor(duty_code);
		ctrl_d.xtal_amp      = amp_code;
		ctrl_d.xtal_bias     = bias_code;
	end

	// Slow clock bus; a source change can glitch it
	logic slow_d;
	assign slow_d = active_xtal_q ? crystal_osc_in
		: (lowspeed_osc_in & ctrl_d.low_osc_on);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_ctrl_o <= '0;
		end else if (ce) begin
			osc_ctrl_o <= ctrl_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slow_clk_o <= 1'b0;
		end else if (ce) begin
			slow_clk_o <= slow_d;
		end
	end

	half_rate_divider u_half (
		.clk      (clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.osc_full (main_osc_48),
		.full_q   (clk48_o),
		.half_q   (clk24_o)
	);
endmodule

// [src/settle_timer.sv]
`timescale 1ns/10ps
// Counts while run is high; done stays high until run drops
module settle_timer #(
	parameter int COUNT = 1
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic run,
	output logic      done_q
);
	localparam int CW = $clog2(COUNT + 1);
	localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          done_d;

	generate
		if (COUNT < 1) begin : g_bad
			$error("settle_timer COUNT must be at least 1");
		end
	endgenerate

	assign cnt_d  = !run ? '0 : (done_q ? cnt_q : cnt_q + CW'(1));
	assign done_d = run & (done_q | (cnt_q == LAST));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else if (ce) begin
			cnt_q  <= cnt_d;
			done_q <= done_d;
		end
	end
endmodule

// [tb/osc_src_checker.sv]
`timescale 1ns/10ps
module osc_src_checker (
	input wire logic                clk,
	input wire logic                resetn,
	input wire logic                ce,
	input wire logic                wb_cyc_i,
	input wire logic                wb_stb_i,
	input wire logic                wb_ack_o,
	input wire logic                main_osc_48,
	input wire logic                sleep_terminal_count,
	input osc_ctrl_pkg::osc_ctrl_s osc_ctrl_o,
	input wire logic                clk48_o,
	input wire logic                clk24_o
);
	logic [2:0] up_q;
	wire        up = up_q == 3'h4;

	// Outputs are trusted only once the reset synchroniser has let go
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			up_q <= 3'h0;
		else if (!up)
			up_q <= up_q + 3'h1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held past one cycle");
	ack_answer_a: assert property
		(up && ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered next cycle");
	full_rate_a: assert property
		(up && ce |=> clk48_o == $past(main_osc_48))
		else $error("full rate output not one cycle late");
	half_toggle_a: assert property
		(up && ce && main_osc_48 && !clk48_o |=> clk24_o != $past(clk24_o))
		else $error("half rate output missed a toggle");
	half_hold_a: assert property
		(up && ce && !(main_osc_48 && !clk48_o) |=> $stable(clk24_o))
		else $error("half rate output toggled early");
	src_switch_a: assert property
		(up && $changed(osc_ctrl_o.slow_src_xtal)
			|-> $past(sleep_terminal_count, 2))
		else $error("slow source changed without terminal count");
	lock_mult_a: assert property
		(up |-> osc_ctrl_o.pll_mult == 10'h2DC)
		else $error("lock multiplier wrong");
	ce_freeze_a: assert property
		(up && !ce |=> $stable(osc_ctrl_o) && $stable(clk48_o)
			&& $stable(clk24_o) && $stable(wb_ack_o))
		else $error("state moved while clock enable low");
	sleep_rate_a: assert property (up |-> osc_ctrl_o.sleep_hz ==
		(osc_ctrl_o.sleep_sel == 2'h3 ? 10'h001 :
		 osc_ctrl_o.sleep_sel == 2'h2 ? 10'h008 :
		 osc_ctrl_o.sleep_sel == 2'h1 ? 10'h040 : 10'h200))
		else $error("sleep rate does not match code");

	cover property (up && sleep_terminal_count);
	cover property (wb_ack_o);
	cover property ($rose(osc_ctrl_o.slow_src_xtal));
endmodule

bind oscillator_source_control osc_src_checker chk (
	.clk                  (clk),
	.resetn               (resetn),
	.ce                   (ce),
	.wb_cyc_i             (wb_cyc_i),
	.wb_stb_i             (wb_stb_i),
	.wb_ack_o             (wb_ack_o),
	.main_osc_48          (main_osc_48),
	.sleep_terminal_count (sleep_terminal_count),
	.osc_ctrl_o           (osc_ctrl_o),
	.clk48_o              (clk48_o),
	.clk24_o              (clk24_o)
);

// [tb/tb_oscillator_source_control.sv]
`timescale 1ns/10ps
module tb_oscillator_source_control;
	logic                    clk, resetn, cyc, stb, we, m48, lso, xso, tc;
	logic                    ack, s_o, ce;
	logic [9:0]              adr;
	logic [3:0]              sel;
	logic [31:0]             wd, rdat, rd;
	osc_ctrl_pkg::osc_ctrl_s oc;
	int                      n_mismatch = 0;
	int                      cmp_count = 0;
	logic [9:0] duty_exp [4] = '{10'h080, 10'h200, 10'h020, 10'h008};
	logic [9:0] hz_exp [4]   = '{10'h200, 10'h040, 10'h008, 10'h001};

	oscillator_source_control #(
		.SETTLE_CYCLES  (20),
		.MAIN_TRIM_5V   (8'hA5),
		.MAIN_TRIM_3V3  (8'h5A),
		.LOW_TRIM_INIT  (6'h15),
		.XTAL_DUTY_INIT (2'h2)
	) dut (
		.clk(clk), .resetn(resetn), .ce(ce),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
		.main_osc_48(m48), .lowspeed_osc_in(lso), .crystal_osc_in(xso),
		.sleep_terminal_count(tc), .osc_ctrl_o(oc), .slow_clk_o(s_o),
		.clk48_o(), .clk24_o()
	);

	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) m48 <= ~m48;

	task automatic test_done;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask

	// One classic cycle; read data is taken at the edge that sees ack
	task automatic wb(input logic w, input logic [7:0] i,
		input logic [7:0] d, input logic [3:0] s = 4'hF);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'h0};
		wd <= {24'h0, d};
		sel <= s;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) begin
			n_mismatch++;
			test_done;
		end
	endtask

	task automatic pause(input int k);
		repeat (k) @(posedge clk);
	endtask

	initial begin
		{cyc, stb, we, tc, m48, xso, resetn} = '0;
		lso = 1'b1;
		ce = 1'b1;
		adr = '0;
		sel = '0;
		wd = '0;
		pause(10);
		resetn <= 1'b1;
		pause(4);
		chk(oc.main_trim, 8'hA5);
		chk(oc.low_trim, 6'h15);
		chk(oc.low_osc_on, 1'b1);
		chk(oc.duty_div, 10'h020);
		chk({oc.xtal_amp, oc.xtal_bias}, 4'h5);
		chk({oc.slow_src_xtal, oc.xtal_enable, oc.pll_enable}, 0);
		chk(s_o, 1'b1);
		wb(0, osc_ctrl_pkg::IDX_TRIM_3V3, 0);
		chk(rd, 32'h5A);
		wb(1, osc_ctrl_pkg::IDX_MAIN_TRIM, 8'h3C);
		wb(0, osc_ctrl_pkg::IDX_MAIN_TRIM, 0);
		chk(rd, 0);
		chk(oc.main_trim, 8'h3C);
		wb(1, osc_ctrl_pkg::IDX_LOW_TRIM, 8'hFF);
		pause(3);
		chk({oc.low_osc_on, oc.low_trim}, 7'h3F);
		chk(s_o, 1'b0);
		wb(1, osc_ctrl_pkg::IDX_LOW_TRIM, 8'h15);
		for (int c = 0; c < 4; c++) begin
			wb(1, osc_ctrl_pkg::IDX_XTAL_TRIM, {c[1:0], 6'h3F});
			wb(1, osc_ctrl_pkg::IDX_CTRL0, {3'h0, c[1:0], 1'b1, c[1:0]});
			pause(2);
			chk(oc.duty_div, duty_exp[c]);
			chk(oc.sleep_hz, hz_exp[c]);
			chk(oc.cpu_sel, {1'b1, c[1:0]});
		end
		chk({oc.xtal_amp, oc.xtal_bias}, 4'hF);
		// Byte lane off and unmapped index both leave state alone
		wb(1, osc_ctrl_pkg::IDX_CTRL0, 8'h00, 4'hE);
		wb(1, 8'h10, 8'hFF);
		wb(0, 8'h10, 0);
		chk(rd, 0);
		wb(0, osc_ctrl_pkg::IDX_CTRL0, 0);
		chk(rd, 32'h1F);
		lso <= 1'b0;
		xso <= 1'b1;
		wb(1, osc_ctrl_pkg::IDX_CTRL0, 8'h98);
		pause(5);
		wb(0, osc_ctrl_pkg::IDX_STATUS, 0);
		chk(rd[1:0], 2'h2);
		chk({oc.xtal_enable, oc.slow_src_xtal}, 2'h2);
		chk(s_o, 1'b0);
		// A terminal count while the clock enable is low must be lost
		ce <= 1'b0;
		tc <= 1'b1;
		@(posedge clk);
		tc <= 1'b0;
		pause(3);
		ce <= 1'b1;
		pause(2);
		chk(oc.slow_src_xtal, 1'b0);
		tc <= 1'b1;
		@(posedge clk);
		tc <= 1'b0;
		pause(3);
		chk(oc.slow_src_xtal, 1'b1);
		chk(s_o, 1'b1);
		wb(0, osc_ctrl_pkg::IDX_STATUS, 0);
		chk(rd[1:0], 2'h1);
		wb(1, osc_ctrl_pkg::IDX_CTRL0, 8'hD8);
		wb(0, osc_ctrl_pkg::IDX_STATUS, 0);
		chk(rd[2], 1'b0);
		chk(oc.pll_enable, 1'b1);
		pause(25);
		wb(0, osc_ctrl_pkg::IDX_STATUS, 0);
		chk(rd[2], 1'b1);
		resetn <= 1'b0;
		pause(2);
		resetn <= 1'b1;
		pause(4);
		chk({oc.slow_src_xtal, oc.main_trim}, 9'h0A5);
		test_done;
	end
endmodule
